// ==== rtl/flag_eval.sv ====
// Purpose: derive nibble carry and overflow from one ALU event
// Assumes: operands are the values the ALU used this cycle
// Notes:   purely combinational
`timescale 1ns/1ps
`include "psw_map.svh"

module flag_eval
    import status_word_pkg::*;
(
    input  wire alu_event_type   i_ev,
    input  wire logic            i_cy,
    output flag_result_type      o_res
);

    always_comb begin
        logic        cin;
        logic [4:0]  nib;
        logic [8:0]  full;
        logic [15:0] prod;
        cin   = 1'b0;
        nib   = 5'h00;
        full  = 9'h000;
        prod  = 16'h0000;
        o_res = '0;
        if (i_ev.valid) begin
            unique case (i_ev.op)
                op_none: begin
                end
                op_add, op_addc: begin
                    cin  = (i_ev.op == op_addc) ? i_cy : 1'b0;
                    nib  = {1'b0, i_ev.a[3:0]} + {1'b0, i_ev.b[3:0]}
                         + {4'h0, cin};
                    full = {1'b0, i_ev.a} + {1'b0, i_ev.b} + {8'h00, cin};
                    o_res.nib_touch = 1'b1;
                    o_res.nib_carry = nib[`NIB_CARRY_BIT];
                    o_res.ovf_touch = 1'b1;
                    o_res.ovf = (i_ev.a[7] == i_ev.b[7])
                             && (full[7] != i_ev.a[7]);
                end
                op_subb: begin
                    nib  = {1'b0, i_ev.a[3:0]} - {1'b0, i_ev.b[3:0]}
                         - {4'h0, i_cy};
                    full = {1'b0, i_ev.a} - {1'b0, i_ev.b} - {8'h00, i_cy};
                    o_res.nib_touch = 1'b1;
                    o_res.nib_carry = nib[`NIB_CARRY_BIT];
                    o_res.ovf_touch = 1'b1;
                    o_res.ovf = (i_ev.a[7] != i_ev.b[7])
                             && (full[7] != i_ev.a[7]);
                end
                op_mul: begin
                    prod = i_ev.a * i_ev.b;
                    o_res.ovf_touch = 1'b1;
                    o_res.ovf       = prod > `BYTE_MAX;
                end
                op_div: begin
                    o_res.ovf_touch = 1'b1;
                    o_res.ovf       = (i_ev.b == 8'h00);
                end
                default: begin
                end
            endcase
        end
    end

endmodule

// ==== rtl/program_status_flags.sv ====
// Purpose: status word flags with AXI4-Lite register access
// Assumes: ALU events and accumulator come from the same clock domain
// Notes:   parity follows the accumulator one cycle late
// Behaviour
// - set nibble carry on nibble carry/borrow
// - clear nibble carry on add, addc, subb without one; mul and div leave it
// - two user flags, software writes only
// - bank select maps R0-R7 to 8-byte banks
// - bank 3 is the top eight bytes
// - signed overflow on add, addc, subb
// - overflow when product exceeds 255
// - overflow on divide by zero
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "psw_map.svh"

module program_status_flags
    import status_word_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    input  wire alu_event_type        i_alu,
    input  wire logic [7:0]           i_acc,
    output logic      [7:0]           o_status_word,
    output logic      [4:0]           o_bank_base,
    input  wire logic [`ADDR_W-1:0]   i_awaddr,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic      [1:0]           o_bresp,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    input  wire logic [`ADDR_W-1:0]   i_araddr,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    output logic      [31:0]          o_rdata,
    output logic      [1:0]           o_rresp,
    output logic                      o_rvalid,
    input  wire logic                 i_rready
);

    function automatic logic [4:0] bank_base(input logic [1:0] sel);
        return {sel, `BANK_LOW_BITS};
    endfunction

    flag_result_type res;
    flag_eval u_eval (
        .i_ev  (i_alu),
        .i_cy  (word_q[`CARRY_BIT]),
        .o_res (res)
    );

    // bus slave state
    logic                aw_hold_q, aw_hold_d;
    logic [`ADDR_W-1:0]  aw_addr_q, aw_addr_d;
    logic                w_hold_q, w_hold_d;
    logic [7:0]          w_byte_q, w_byte_d;
    logic                w_lane_q, w_lane_d;
    logic                awready_q, awready_d;
    logic                wready_q, wready_d;
    logic                bvalid_q, bvalid_d;
    logic [1:0]          bresp_q, bresp_d;
    logic                arready_q, arready_d;
    logic                rvalid_q, rvalid_d;
    logic [1:0]          rresp_q, rresp_d;
    logic [31:0]         rdata_q, rdata_d;
    logic                do_write;
    logic                word_wr;

    // status word state
    logic [7:0]          word_q, word_d;
    logic [4:0]          base_q, base_d;

    always_comb begin
        aw_hold_d = aw_hold_q | (i_awvalid & awready_q);
        aw_addr_d = (i_awvalid & awready_q) ? i_awaddr : aw_addr_q;
        w_hold_d  = w_hold_q | (i_wvalid & wready_q);
        w_byte_d  = (i_wvalid & wready_q) ? i_wdata[7:0] : w_byte_q;
        w_lane_d  = (i_wvalid & wready_q) ? i_wstrb[0] : w_lane_q;
        bvalid_d  = bvalid_q & ~i_bready;
        bresp_d   = bresp_q;
        // both halves held and no answer pending: commit now
        do_write  = aw_hold_q & w_hold_q & ~bvalid_q;
        word_wr   = do_write & (aw_addr_q == `STATUS_OFFSET) & w_lane_q;
        if (do_write) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (aw_addr_q == `STATUS_OFFSET) ? `RESP_OKAY
                                                      : `RESP_SLVERR;
        end
        awready_d = ~aw_hold_d & ~(do_write | bvalid_q);
        wready_d  = ~w_hold_d & ~(do_write | bvalid_q);
    end

    always_comb begin
        rvalid_d = rvalid_q & ~i_rready;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (i_arvalid & arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = `RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            unique case (i_araddr)
                `STATUS_OFFSET: rdata_d[7:0] = word_q;
                `BANK_OFFSET: rdata_d[4:0] = base_q;
                default:      rresp_d      = `RESP_SLVERR;
            endcase
        end
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= '0;
            w_hold_q  <= 1'b0;
            w_byte_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= `RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else begin
            aw_hold_q <= aw_hold_d;
            aw_addr_q <= aw_addr_d;
            w_hold_q  <= w_hold_d;
            w_byte_q  <= w_byte_d;
            w_lane_q  <= w_lane_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // alu result beats a software write to the same flag
    always_comb begin
        word_d = word_q;
        if (word_wr) begin
            word_d[`CARRY_BIT]    = w_byte_q[`CARRY_BIT];
            word_d[`NIB_FLAG_BIT] = w_byte_q[`NIB_FLAG_BIT];
            word_d[`USER0_BIT]    = w_byte_q[`USER0_BIT];
            word_d[`USER1_BIT]    = w_byte_q[`USER1_BIT];
            word_d[`BS_HI_BIT:`BS_LO_BIT] =
                w_byte_q[`BS_HI_BIT:`BS_LO_BIT];
            word_d[`OVF_BIT]      = w_byte_q[`OVF_BIT];
        end
        if (res.nib_touch) begin
            word_d[`NIB_FLAG_BIT] = res.nib_carry;
        end
        if (res.ovf_touch) begin
            word_d[`OVF_BIT] = res.ovf;
        end
        word_d[`PAR_BIT] = ^i_acc;
        base_d = bank_base(word_d[`BS_HI_BIT:`BS_LO_BIT]);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            word_q <= `STATUS_RESET;
            base_q <= 5'h00;
        end else begin
            word_q <= word_d;
            base_q <= base_d;
        end
    end

    assign o_status_word = word_q;
    assign o_bank_base   = base_q;
    assign o_awready   = awready_q;
    assign o_wready    = wready_q;
    assign o_bvalid    = bvalid_q;
    assign o_bresp     = bresp_q;
    assign o_arready   = arready_q;
    assign o_rvalid    = rvalid_q;
    assign o_rresp     = rresp_q;
    assign o_rdata     = rdata_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_nib_set;
        i_alu.valid && i_alu.op == op_add
        && ({1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]}) > 5'h0f
        |=> o_status_word[`NIB_FLAG_BIT];
    endproperty
    a_nib_set: assert property (p_nib_set)
        else $error("nibble carry not set");

    property p_nib_clr;
        i_alu.valid && i_alu.op == op_subb
        && i_alu.a[3:0] > i_alu.b[3:0]
        |=> !o_status_word[`NIB_FLAG_BIT];
    endproperty
    a_nib_clr: assert property (p_nib_clr)
        else $error("nibble carry not cleared");

    property p_user_hold;
        !word_wr |=> $stable(o_status_word[`USER0_BIT])
                     && $stable(o_status_word[`USER1_BIT]);
    endproperty
    a_user_hold: assert property (p_user_hold)
        else $error("user flag changed without a write");

    property p_bank_map;
        o_bank_base == {o_status_word[`BS_HI_BIT:`BS_LO_BIT],
                        `BANK_LOW_BITS};
    endproperty
    a_bank_map: assert property (p_bank_map)
        else $error("bank base does not follow bank select");

    property p_bank_top;
        o_status_word[`BS_HI_BIT:`BS_LO_BIT] == 2'h3
        |-> o_bank_base + `BANK_TOP_IDX == `BANK_LAST;
    endproperty
    a_bank_top: assert property (p_bank_top)
        else $error("bank 3 not at the top of the area");

    property p_ovf_add;
        i_alu.valid && i_alu.op == op_add
        && !i_alu.a[7] && !i_alu.b[7] && (i_alu.a[6] && i_alu.b[6])
        |=> o_status_word[`OVF_BIT];
    endproperty
    a_ovf_add: assert property (p_ovf_add)
        else $error("signed overflow missed");

    property p_ovf_mul;
        i_alu.valid && i_alu.op == op_mul
        && (16'(i_alu.a) * 16'(i_alu.b)) > `BYTE_MAX
        |=> o_status_word[`OVF_BIT];
    endproperty
    a_ovf_mul: assert property (p_ovf_mul)
        else $error("product overflow missed");

    property p_ovf_div;
        i_alu.valid && i_alu.op == op_div
        |=> o_status_word[`OVF_BIT] == ($past(i_alu.b) == 8'h00);
    endproperty
    a_ovf_div: assert property (p_ovf_div)
        else $error("divide by zero flag wrong");

    property p_parity;
        ##1 o_status_word[`PAR_BIT] == ^$past(i_acc);
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity does not match accumulator");

    property p_write_resp;
        aw_hold_q && w_hold_q && !bvalid_q |=> o_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write response missing");

    c_write: cover property (word_wr ##1 o_bvalid && i_bready);
    c_read:  cover property (o_rvalid && i_rready);
    c_div0:  cover property (i_alu.valid && i_alu.op == op_div
                             && i_alu.b == 8'h00);

endmodule

// ==== rtl/psw_map.svh ====
// Purpose: offsets, field positions and reset values of the status word
// Assumes: included by bare name wherever the status word is decoded
// Notes:   byte addresses on the register bus
`ifndef STATUS_WORD_MAP_SVH
`define STATUS_WORD_MAP_SVH

`define ADDR_W        4
`define STATUS_OFFSET 4'h0
`define BANK_OFFSET   4'h4
`define STATUS_RESET  8'h00
`define CARRY_BIT     7
`define NIB_FLAG_BIT  6
`define USER0_BIT     5
`define BS_HI_BIT     4
`define BS_LO_BIT     3
`define OVF_BIT       2
`define USER1_BIT     1
`define PAR_BIT       0
`define BANK_LOW_BITS 3'h0
`define BANK_LAST     5'h1f
`define BANK_TOP_IDX  5'h07
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define NIB_CARRY_BIT 4
`define BYTE_MAX      16'h00ff

`endif

// ==== rtl/psw_pkg.sv ====
// Purpose: types shared by the status word logic
// Assumes: nothing
// Notes:   the ALU event travels as one packed struct
package status_word_pkg;

    typedef enum logic [2:0] {
        op_none,
        op_add,
        op_addc,
        op_subb,
        op_mul,
        op_div
    } alu_op_type;

    typedef struct packed {
        logic       valid;
        alu_op_type op;
        logic [7:0] a;
        logic [7:0] b;
    } alu_event_type;

    typedef struct packed {
        logic nib_touch;
        logic nib_carry;
        logic ovf_touch;
        logic ovf;
    } flag_result_type;

endpackage

// ==== verif/alu_core_model.sv ====
// Purpose: stand-in for the core ALU issuing flag events
// Assumes: the bench asks for one event at a time
// Notes:   operands are scrambled while valid is low
`timescale 1ns/1ps

module alu_core_model
    import status_word_pkg::*;
(
    input  wire logic          i_clk,
    input  wire logic          i_fire,
    input  wire alu_op_type    i_op,
    input  wire logic [7:0]    i_a,
    input  wire logic [7:0]    i_b,
    input  wire logic [7:0]    i_acc,
    output alu_event_type      o_ev,
    output logic      [7:0]    o_acc
);
    always_ff @(posedge i_clk) begin
        o_acc <= i_acc;
        if (i_fire) begin
            o_ev <= '{1'b1, i_op, i_a, i_b};
        end else begin
            // no stale operands between events
            o_ev <= '{1'b0, op_none, ~i_a, ~i_b};
        end
    end
endmodule

// ==== verif/program_status_flags_bench.sv ====
// Purpose: self-checking bench for the status word flags
// Assumes: bready and rready stay high; answers awaited without bound
// Notes:   expectations come from the bench's own flag function
`timescale 1ns/1ps

module program_status_flags_bench
    import status_word_pkg::*;
    ;
    logic          clk, rstn, fire, awvalid, wvalid, arvalid;
    logic          awready, wready, arready, bvalid, rvalid;
    logic [3:0]    awaddr, araddr;
    logic [31:0]   wdata, rdata, st, r;
    logic [1:0]    bresp, rresp;
    logic [7:0]    a_s, b_s, acc_s, acc, word, ep;
    logic [4:0]    base;
    alu_op_type    op_s, o;
    alu_event_type ev;
    int            miscompares, n_compared;
    alu_op_type    co[8] = '{op_add, op_add, op_subb, op_mul, op_div,
                             op_subb, op_mul, op_div};
    logic [15:0]   cab[8] = '{16'h0f01, 16'h7f01, 16'h1001, 16'h1010,
                              16'h0900, 16'h8001, 16'h0f11, 16'h0503};

    alu_core_model core (.i_clk(clk), .i_fire(fire), .i_op(op_s),
        .i_a(a_s), .i_b(b_s), .i_acc(acc_s), .o_ev(ev),
        .o_acc(acc));
    program_status_flags dut (.i_clk(clk), .i_rstn(rstn), .i_alu(ev),
        .i_acc(acc), .o_status_word(word), .o_bank_base(base),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(1'b1));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] nxt();
        st = {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
        return st;
    endfunction

    // returns {nibble carry, overflow}; old pair kept where untouched
    function automatic logic [1:0] flags(input alu_op_type op,
        input logic [7:0] a, input logic [7:0] b, input logic c,
        input logic [1:0] old);
        logic [8:0]  s;
        logic [4:0]  n;
        logic [15:0] p;
        flags = old;
        if (op == op_add || op == op_addc) begin
            c = c & (op == op_addc);
            n = {1'b0, a[3:0]} + b[3:0] + c;
            s = {1'b0, a} + b + c;
            flags = {n[4], (a[7] == b[7]) && (s[7] != a[7])};
        end else if (op == op_subb) begin
            n = {1'b0, a[3:0]} - b[3:0] - c;
            s = {1'b0, a} - b - c;
            flags = {n[4], (a[7] != b[7]) && (s[7] != a[7])};
        end else if (op == op_mul) begin
            p = a * b;
            flags[0] = (p[15:8] != 8'h00);
        end else if (op == op_div) begin
            flags[0] = (b == 8'h00);
        end
    endfunction

    task automatic complete_run();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
    endtask

    // one event, then the answer edge has landed before the compare
    task automatic alu(input alu_op_type op, input logic [7:0] a,
                       input logic [7:0] b, input logic [7:0] c);
        @(posedge clk);
        fire <= 1'b1;
        op_s <= op;
        a_s <= a;
        b_s <= b;
        acc_s <= c;
        @(posedge clk);
        fire <= 1'b0;
        repeat (3) @(posedge clk);
        {ep[6], ep[2]} = flags(op, a, b, ep[7], {ep[6], ep[2]});
        ep[0] = ^c;
        chk(32'(word), 32'(ep));
    endtask

    initial begin
        st = 32'h5b4d8c4d;
        miscompares = 0;
        n_compared = 0;
        {rstn, fire, awvalid, wvalid, arvalid} = 5'h00;
        {awaddr, araddr, wdata, a_s, b_s, acc_s} = '0;
        op_s = op_none;
        ep = 8'h00;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(4'h0, 32'h0, 2'h0);
        for (int k = 0; k < 4; k++) begin
            wr_reg(4'h0, 32'(k << 3), 2'h0);
            rd_reg(4'h4, 32'(k * 8), 2'h0);
            chk(32'(base), 32'(k * 8));
        end
        // the last bank write left bank 3 selected, all else clear
        ep[4:3] = 2'h3;
        wr_reg(4'h8, 32'hff, 2'h2);
        rd_reg(4'h8, 32'h0, 2'h2);
        for (int i = 0; i < 80; i++) begin
            r = nxt();
            if (i % 8 == 7) begin
                ep = {r[7:1], ^acc_s};
                wr_reg(4'h0, 32'(r[15:0]), 2'h0);
                rd_reg(4'h0, 32'(ep), 2'h0);
                chk(32'(base), 32'({ep[4:3], 3'h0}));
            end
            if (i < 8) begin
                alu(co[i], cab[i][15:8], cab[i][7:0], r[7:0]);
            end else begin
                o = alu_op_type'(3'(1 + r[31:24] % 5));
                alu(o, r[7:0], (r[23]) ? 8'h00 : r[15:8], r[22:15]);
            end
        end
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule
